// ### rtl/fcr_map.vh
// constants for the continuous main-array read front end
// Function
// - instruction: select falls, opcode, then address
// - each rising clock edge shifts opcode and address in
// - all fields and data travel msb first
// - buffer byte chosen by eleven-bit offset
// - array byte: thirteen-bit page, eleven-bit offset
// - four clocking modes, category chosen by opcode
// - opcode 68H or E8H plus three address bytes
// - top thirteen bits page, low eleven offset
// - four serial or sixty parallel dummy bytes
// - after dummies each clock drives read data
// - address counter advances during data output
// - page end rolls to next page, no gap
// - array end wraps to page zero, no gap
// - select rising ends read, outputs released
// - read uses main array, buffers untouched
`ifndef FCR_MAP_VH
`define FCR_MAP_VH

// opcodes
`define FCR_OP_CAR_CLKPOL 8'h68
`define FCR_OP_CAR_SPI 8'hE8

// address field layout inside the 24-bit sequence
`define FCR_ADDR_W 24
`define FCR_PAGE_W 13
`define FCR_OFFS_W 11
`define FCR_PAGE_MSB 23
`define FCR_PAGE_LSB 11
`define FCR_OFFS_MSB 10
`define FCR_OFFS_LSB 0
`define FCR_BUF_OFFS_W 11

// array geometry
`define FCR_PAGE_LAST_BYTE 11'h041F
`define FCR_PAGE_RST 13'h0000
`define FCR_OFFS_RST 11'h000

// phase lengths in bytes
`define FCR_ADDR_BYTES 6'h03
`define FCR_DUMMY_SER_BYTES 6'h04
`define FCR_DUMMY_PAR_BYTES 6'h3C

// interface select level that picks the serial lines
`define FCR_ISEL_SERIAL 1'b1

`endif

// ### rtl/fcr_sync.v
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
module fcr_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // pins and their synchronised copies
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= async_in[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_q;
endmodule

// ### rtl/fcr_top.v
// command front end and continuous main-array read path
`timescale 1ns/1ns
`include "fcr_map.vh"
module fcr_top (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // host pins
    input wire cs_n_in,
    input wire sck_in,
    input wire si_in,
    input wire interface_select_in,
    input wire [7:0] parallel_data_lines_in,
    output reg so_out,
    output reg so_oe_out,
    output reg [7:0] parallel_data_lines_out,
    output reg parallel_data_lines_oe_out,
    // main array read port
    output reg array_rd_out,
    output reg [`FCR_PAGE_W-1:0] array_page_out,
    output reg [`FCR_OFFS_W-1:0] array_offset_out,
    input wire [7:0] array_data_in
);
    localparam ST_IDLE = 3'd0;
    localparam ST_OPC = 3'd1;
    localparam ST_ADDR = 3'd2;
    localparam ST_DUMMY = 3'd3;
    localparam ST_DATA = 3'd4;
    localparam ST_IGNORE = 3'd5;

    // every pin passes two flops before any logic reads it
    wire [11:0] pins_s;
    fcr_sync #(
        .WIDTH(12)
    ) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in({cs_n_in, sck_in, si_in, interface_select_in,
                   parallel_data_lines_in}),
        .sync_out(pins_s)
    );

    wire cs_n_s = pins_s[11];
    wire sck_s = pins_s[10];
    wire si_s = pins_s[9];
    wire isel_s = pins_s[8];
    wire [7:0] pd_s = pins_s[7:0];

    reg [2:0] state_q, state_d;
    reg sck_prev_q;
    reg cs_n_prev_q;
    reg serial_q, serial_d;
    reg spi_cat_q, spi_cat_d;
    reg [6:0] rx_q, rx_d;
    reg [2:0] rx_bit_q, rx_bit_d;
    reg [5:0] byte_cnt_q, byte_cnt_d;
    reg [15:0] addr_hi_q, addr_hi_d;
    reg [2:0] tx_bit_q, tx_bit_d;
    reg [7:0] tx_shift_q, tx_shift_d;
    reg so_d;
    reg so_oe_d;
    reg [7:0] pd_out_d;
    reg pd_oe_d;
    reg rd_d;
    reg [`FCR_PAGE_W-1:0] page_d;
    reg [`FCR_OFFS_W-1:0] offs_d;

    wire sck_rise = sck_s & ~sck_prev_q;
    wire sck_fall = ~sck_s & sck_prev_q;
    wire cs_fall = ~cs_n_s & cs_n_prev_q;

    // assembled byte this edge: shifted serial bits or the whole port
    wire [7:0] rx_byte = serial_q ? {rx_q, si_s} : pd_s;
    wire rx_done = serial_q ? (rx_bit_q == 3'd7) : 1'b1;
    wire [5:0] dummy_len = serial_q ? `FCR_DUMMY_SER_BYTES
                                    : `FCR_DUMMY_PAR_BYTES;
    // spi category updates on the falling edge, polarity category
    // on the rising edge; host samples on the opposite edge
    wire out_edge = spi_cat_q ? sck_fall : sck_rise;
    // full 24-bit address as it lands with the third address byte
    wire [`FCR_ADDR_W-1:0] addr_full = {addr_hi_q, rx_byte};

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            // match the synchroniser's reset level so that no false
            // select edge follows reset
            sck_prev_q <= 1'b0;
            cs_n_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
            cs_n_prev_q <= cs_n_s;
        end
    end

    always @* begin
        state_d = state_q;
        serial_d = serial_q;
        spi_cat_d = spi_cat_q;
        rx_d = rx_q;
        rx_bit_d = rx_bit_q;
        byte_cnt_d = byte_cnt_q;
        addr_hi_d = addr_hi_q;
        tx_bit_d = tx_bit_q;
        tx_shift_d = tx_shift_q;
        so_d = so_out;
        so_oe_d = so_oe_out;
        pd_out_d = parallel_data_lines_out;
        pd_oe_d = parallel_data_lines_oe_out;
        rd_d = array_rd_out;
        page_d = array_page_out;
        offs_d = array_offset_out;

        if (cs_n_s) begin
            // released select aborts at once, whatever the phase
            state_d = ST_IDLE;
            so_oe_d = 1'b0;
            pd_oe_d = 1'b0;
            rd_d = 1'b0;
        end else if (cs_fall) begin
            // a new instruction starts only on the select edge
            state_d = ST_OPC;
            serial_d = (isel_s == `FCR_ISEL_SERIAL);
            rx_bit_d = 3'd0;
            byte_cnt_d = 6'h00;
            tx_bit_d = 3'd0;
        end else begin
            case (state_q)
                ST_OPC, ST_ADDR, ST_DUMMY: begin
                    if (sck_rise) begin
                        // bits arrive msb first on the serial line
                        rx_d = rx_byte[6:0];
                        rx_bit_d = rx_bit_q + 3'd1;
                        if (rx_done) begin
                            byte_cnt_d = byte_cnt_q + 6'h01;
                            if (state_q == ST_OPC) begin
                                byte_cnt_d = 6'h00;
                                if (rx_byte == `FCR_OP_CAR_CLKPOL ||
                                    rx_byte == `FCR_OP_CAR_SPI) begin
                                    state_d = ST_ADDR;
                                    spi_cat_d = (rx_byte ==
                                        `FCR_OP_CAR_SPI);
                                end else begin
                                    // other commands live elsewhere
                                    state_d = ST_IGNORE;
                                end
                            end else if (state_q == ST_ADDR) begin
                                addr_hi_d = addr_full[15:0];
                                if (byte_cnt_q ==
                                    `FCR_ADDR_BYTES - 6'h01) begin
                                    state_d = ST_DUMMY;
                                    byte_cnt_d = 6'h00;
                                    page_d = addr_full[`FCR_PAGE_MSB:
                                        `FCR_PAGE_LSB];
                                    offs_d = addr_full[`FCR_OFFS_MSB:
                                        `FCR_OFFS_LSB];
                                    // only the main array is addressed
                                    rd_d = 1'b1;
                                end
                            end else if (byte_cnt_q ==
                                         dummy_len - 6'h01) begin
                                state_d = ST_DATA;
                                tx_bit_d = 3'd0;
                                so_d = 1'b0;
                                so_oe_d = serial_q;
                                pd_oe_d = ~serial_q;
                            end
                        end
                    end
                end
                ST_DATA: begin
                    if (out_edge) begin
                        if (serial_q) begin
                            tx_bit_d = tx_bit_q + 3'd1;
                            if (tx_bit_q == 3'd0) begin
                                so_d = array_data_in[7];
                                tx_shift_d = {array_data_in[6:0], 1'b0};
                            end else begin
                                so_d = tx_shift_q[7];
                                tx_shift_d = {tx_shift_q[6:0], 1'b0};
                            end
                        end else begin
                            pd_out_d = array_data_in;
                        end
                        // step once the current byte is captured so
                        // the next byte is ready before it is needed
                        if (!serial_q || tx_bit_q == 3'd0) begin
                            if (array_offset_out ==
                                `FCR_PAGE_LAST_BYTE) begin
                                offs_d = `FCR_OFFS_RST;
                                // last page rolls over to page zero
                                page_d = array_page_out +
                                    {{(`FCR_PAGE_W-1){1'b0}},
                                     1'b1};
                            end else begin
                                offs_d = array_offset_out +
                                    {{(`FCR_OFFS_W-1){1'b0}},
                                     1'b1};
                            end
                        end
                    end
                end
                ST_IGNORE: begin
                    state_d = ST_IGNORE;
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            serial_q <= 1'b1;
            spi_cat_q <= 1'b0;
            rx_q <= 7'h00;
            rx_bit_q <= 3'd0;
            byte_cnt_q <= 6'h00;
            addr_hi_q <= 16'h0000;
            tx_bit_q <= 3'd0;
            tx_shift_q <= 8'h00;
            so_out <= 1'b0;
            so_oe_out <= 1'b0;
            parallel_data_lines_out <= 8'h00;
            parallel_data_lines_oe_out <= 1'b0;
            array_rd_out <= 1'b0;
            array_page_out <= `FCR_PAGE_RST;
            array_offset_out <= `FCR_OFFS_RST;
        end else begin
            state_q <= state_d;
            serial_q <= serial_d;
            spi_cat_q <= spi_cat_d;
            rx_q <= rx_d;
            rx_bit_q <= rx_bit_d;
            byte_cnt_q <= byte_cnt_d;
            addr_hi_q <= addr_hi_d;
            tx_bit_q <= tx_bit_d;
            tx_shift_q <= tx_shift_d;
            so_out <= so_d;
            so_oe_out <= so_oe_d;
            parallel_data_lines_out <= pd_out_d;
            parallel_data_lines_oe_out <= pd_oe_d;
            array_rd_out <= rd_d;
            array_page_out <= page_d;
            array_offset_out <= offs_d;
        end
    end
endmodule

// ### sim/fcr_array_model.sv
// main array model: each byte is a fixed function of page and offset
`timescale 1ns/1ns
module fcr_array_model (
    // clock
    input wire logic clk_in,
    // read port
    input wire logic [12:0] page_in,
    input wire logic [10:0] offset_in,
    output logic [7:0] data_out
);
    // one cycle of latency stays inside the two-cycle allowance
    always @(posedge clk_in) begin
        data_out <= {page_in[3:0], 4'h0} ^ offset_in[7:0]
            ^ {5'h00, offset_in[10:8]};
    end
endmodule

// ### sim/fcr_top_asserts.sv
// concurrent checks on the continuous read front end ports
`timescale 1ns/1ns
module fcr_top_asserts (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // watched pins
    input wire cs_n_in,
    input wire so_oe_out,
    input wire parallel_data_lines_oe_out,
    input wire array_rd_out,
    input wire [12:0] array_page_out,
    input wire [10:0] array_offset_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    property p_oe_one;
        !(so_oe_out && parallel_data_lines_oe_out);
    endproperty
    a_oe_one: assert property (p_oe_one)
        else $error("both outputs enabled");
    property p_cs_release;
        cs_n_in [*5] |-> !so_oe_out && !parallel_data_lines_oe_out;
    endproperty
    a_cs_release: assert property (p_cs_release)
        else $error("outputs driven after select rose");
    property p_cs_rd;
        cs_n_in [*5] |-> !array_rd_out;
    endproperty
    a_cs_rd: assert property (p_cs_rd)
        else $error("read still active after select rose");
    property p_oe_hold;
        !cs_n_in [*4] ##0 so_oe_out |=> so_oe_out;
    endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("serial output dropped while selected");
    property p_so_rose;
        $rose(so_oe_out) |-> !cs_n_in && array_rd_out;
    endproperty
    a_so_rose: assert property (p_so_rose)
        else $error("serial output enabled outside a read");
    property p_pd_rose;
        $rose(parallel_data_lines_oe_out) |-> !cs_n_in && array_rd_out;
    endproperty
    a_pd_rose: assert property (p_pd_rose)
        else $error("parallel output enabled outside a read");
    property p_offs_step;
        array_rd_out && $past(array_rd_out) && $changed(array_offset_out)
        |-> array_offset_out == $past(array_offset_out) + 11'h001
        || array_offset_out == 11'h000;
    endproperty
    a_offs_step: assert property (p_offs_step)
        else $error("offset did not step by one");
    property p_page_step;
        array_rd_out && $past(array_rd_out) && $changed(array_page_out)
        |-> array_offset_out == 11'h000
        && $past(array_offset_out) == 11'h041F
        && array_page_out == $past(array_page_out) + 13'h0001;
    endproperty
    a_page_step: assert property (p_page_step)
        else $error("bad page crossing");
endmodule
bind fcr_top fcr_top_asserts u_fcr_top_asserts (
    .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in),
    .so_oe_out(so_oe_out),
    .parallel_data_lines_oe_out(parallel_data_lines_oe_out),
    .array_rd_out(array_rd_out), .array_page_out(array_page_out),
    .array_offset_out(array_offset_out));

// ### sim/tb_fcr_top.sv
// testbench: continuous array reads over serial and parallel links
`timescale 1ns/1ns
`include "fcr_map.vh"
module tb_fcr_top;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cs_n_in = 1'b1;
    logic sck_in = 1'b1;
    logic si_in = 1'b0;
    logic isel = 1'b1;
    logic [7:0] pd_in = 8'h00;
    logic so_out, so_oe_out, pd_oe_out, array_rd_out;
    logic [7:0] pd_out, array_data, sh;
    logic [12:0] page;
    logic [10:0] offset;
    logic [7:0] exp_q[$];
    logic [7:0] lfsr = 8'h1F;
    logic mon_on = 1'b0;
    logic skip, ser, rise_out;
    int error_cnt = 0, n_checks = 0, cyc = 0, nbit = 0;
    always #2 clk_in = ~clk_in;
    fcr_top u_fcr_top (.clk_in(clk_in), .rst_in(rst_in),
        .cs_n_in(cs_n_in), .sck_in(sck_in), .si_in(si_in),
        .interface_select_in(isel), .parallel_data_lines_in(pd_in),
        .so_out(so_out), .so_oe_out(so_oe_out),
        .parallel_data_lines_out(pd_out),
        .parallel_data_lines_oe_out(pd_oe_out),
        .array_rd_out(array_rd_out), .array_page_out(page),
        .array_offset_out(offset), .array_data_in(array_data));
    fcr_array_model u_fcr_array_model (.clk_in(clk_in), .page_in(page),
        .offset_in(offset), .data_out(array_data));
    function automatic logic [7:0] nxt();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t data got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t flag got %b exp %b", $time, g, e);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one byte per unit: eight sck periods when serial, one when parallel
    task automatic unit(input logic [7:0] b);
        int i;
        for (i = (ser ? 7 : 0); i >= 0; i--) begin
            @(posedge clk_in);
            sck_in <= 1'b0;
            si_in <= b[i];
            pd_in <= b;
            repeat (4) @(posedge clk_in);
            sck_in <= 1'b1;
            repeat (3) @(posedge clk_in);
        end
    endtask
    task automatic frame(input logic s, input logic [7:0] op,
                         input logic [12:0] pg, input logic [10:0] of);
        int i;
        logic ok;
        ok = (op == `FCR_OP_CAR_SPI) || (op == `FCR_OP_CAR_CLKPOL);
        ser = s;
        rise_out = (op == `FCR_OP_CAR_CLKPOL);
        @(posedge clk_in);
        isel <= s;
        @(posedge clk_in);
        cs_n_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        unit(op);
        unit({pg[12:5]});
        unit({pg[4:0], of[10:8]});
        unit(of[7:0]);
        for (i = 0; i < (s ? 4 : 60); i++) unit(nxt());
        skip = 1'b1;
        nbit = 0;
        mon_on = ok;
        for (i = 0; ok && i < 3; i++) begin
            exp_q.push_back({pg[3:0], 4'h0} ^ of[7:0] ^ {5'h00, of[10:8]});
            if (of == 11'h041F) begin
                of = 11'h000;
                pg = pg + 13'h0001;
            end else
                of = of + 11'h001;
        end
        // one skipped edge, then three whole bytes; serial tail bits unread
        for (i = 0; i < 4; i++) unit(nxt());
        if (!ok) chk1(1'b0, so_oe_out | pd_oe_out);
        @(posedge clk_in);
        cs_n_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        mon_on = 1'b0;
        chk1(1'b0, so_oe_out | pd_oe_out);
        chk1(1'b1, exp_q.size() == 0);
        $display("test op %h serial %b done", op, s);
    endtask
    task automatic take(input logic [7:0] v);
        if (exp_q.size() == 0) begin
            error_cnt++;
            $display("[ERR] %0t unexpected byte %h", $time, v);
        end else
            chk(exp_q.pop_front(), v);
    endtask
    // samples on the next output edge, when the previous unit is settled
    always @(sck_in) begin
        if (mon_on && (sck_in === rise_out)) begin
            if (skip)
                skip = 1'b0;
            else if (!ser)
                take(pd_out);
            else begin
                sh = {sh[6:0], so_out};
                nbit++;
                if (nbit == 8) begin
                    nbit = 0;
                    take(sh);
                end
            end
        end
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            give_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        frame(1'b1, `FCR_OP_CAR_SPI, 13'h0005, 11'h041E);
        frame(1'b0, `FCR_OP_CAR_CLKPOL, 13'h1FFF, 11'h041F);
        frame(1'b1, `FCR_OP_CAR_CLKPOL, {5'h00, nxt()}, 11'h041F);
        frame(1'b0, `FCR_OP_CAR_SPI, {nxt(), 5'h1F}, 11'h0400);
        frame(1'b1, 8'h52, 13'h0000, 11'h0000);
        give_verdict();
    end
endmodule
